// ===== adc_seq_regs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ----
// Register offsets
// ----
`define ADC_MAIN_CONTROL_ADDR 8'h00
`define ADC_ACCUM_CONTROL_ADDR 8'h01
`define ADC_REF_CLK_CONTROL_ADDR 8'h02
`define ADC_TIMING_CONTROL_ADDR 8'h03
`define ADC_WINDOW_MODE_CONTROL_ADDR 8'h04
`define ADC_SAMPLE_LENGTH_CONTROL_ADDR 8'h05
`define ADC_INPUT_CHANNEL_SELECT_ADDR 8'h06
`define ADC_CONVERSION_COMMAND_ADDR 8'h08
`define ADC_EVENT_TRIGGER_CONTROL_ADDR 8'h09
`define ADC_INTERRUPT_ENABLE_ADDR 8'h0A
`define ADC_INTERRUPT_FLAG_STATUS_ADDR 8'h0B
`define ADC_DEBUG_HALT_CONTROL_ADDR 8'h0C
`define ADC_RESULT_LOW_ADDR 8'h10
`define ADC_RESULT_HIGH_ADDR 8'h11
`define ADC_WIN_LOW_LOW_ADDR 8'h12
`define ADC_WIN_LOW_HIGH_ADDR 8'h13
`define ADC_WIN_HIGH_LOW_ADDR 8'h14
`define ADC_WIN_HIGH_HIGH_ADDR 8'h15

// ----
// Field positions
// ----
`define ADC_ENABLE_BIT 0
`define ADC_FREE_RUNNING_BIT 1
`define ADC_RESOLUTION_SELECT_BIT 2
`define ADC_SAMPLE_CAP_BIT 6
`define ADC_REFERENCE_SELECT_LSB 4
`define ADC_STARTUP_DELAY_LSB 5
`define ADC_AUTO_DELAY_BIT 4
`define ADC_RESULT_READY_BIT 0
`define ADC_WINDOW_MATCH_BIT 1

// ----
// Reset values and codes
// ----
`define ADC_REG_RESET 8'h00
`define ADC_WORD_RESET 16'h0000
`define ADC_REF_INTERNAL 2'h0
`define ADC_REF_SUPPLY 2'h1
`define ADC_REF_EXTERNAL 2'h2
`define ADC_WIN_NONE 3'h0
`define ADC_WIN_BELOW 3'h1
`define ADC_WIN_ABOVE 3'h2
`define ADC_WIN_INSIDE 3'h3
`define ADC_WIN_OUTSIDE 3'h4
`define ADC_CHAN_LAST_PIN 5'h0F
`define ADC_CHAN_COMP_REF 5'h1C
`define ADC_CHAN_TEMP 5'h1E
`define ADC_CHAN_GROUND 5'h1F
`define ADC_STARTUP_MAX_CODE 3'h5
`define ADC_STARTUP_BASE 9'h008
`define ADC_ACCUM_MAX_CODE 3'h6
`define ADC_SAMPLE_BASE_CYCLES 6'h02

`endif

// ===== adc_seq_pkg.sv
// Types shared by the conversion sequencer
`default_nettype none

package adc_seq_pkg;

    // Sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STARTUP = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b011,
        ST_GAP = 3'b100
    } seq_state_t;

    // Whole state of the sequencer
    typedef struct packed {
        logic [1:0] rstSync;
        logic enable;
        logic free_running;
        logic resolution_select;
        logic [2:0] accumCount;
        logic sample_capacitor_size;
        logic [1:0] reference_select;
        logic [2:0] clkDiv;
        logic [2:0] startupDly;
        logic autoDelay;
        logic [3:0] gapDly;
        logic [2:0] windowMode;
        logic [4:0] sampleLenExt;
        logic [4:0] inputChannel;
        logic startConv;
        logic eventStartEn;
        logic [1:0] intEnable;
        logic [1:0] interrupt_flag_status;
        logic debugRun;
        logic [15:0] winLow;
        logic [15:0] winHigh;
        logic [15:0] result;
        seq_state_t state;
        logic [7:0] prescCnt;
        logic [8:0] phaseCnt;
        logic [6:0] sampleIdx;
        logic [15:0] accum;
        logic [4:0] activeChannel;
        logic initPending;
        logic evMeta;
        logic evSync;
        logic evPrev;
        logic convertStart;
        logic sampleOpen;
        logic [2:0] refDecode;
        logic [15:0] pinSelect;
        logic [2:0] auxSelect;
        logic [7:0] rdData;
        logic irq;
    } seq_regs_t;

endpackage : adc_seq_pkg

`default_nettype wire

// ===== adc_conversion_sequencer.sv
// Conversion sequencer: clock divider, timing, channel, window, flags
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.svh"

module adc_conversion_sequencer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic startEvent,
    input wire logic debugHalt,
    input wire logic wakeMeasure,
    input wire logic sampleDone,
    input wire logic [9:0] sampleData,
    output logic converterTick,
    output logic sampleOpen,
    output logic convertStart,
    output logic [4:0] activeChannel,
    output logic [15:0] pinSelect,
    output logic compRefSelect,
    output logic tempSensorSelect,
    output logic groundSelect,
    output logic refInternal,
    output logic refSupply,
    output logic refExternal,
    output logic sampleCapReduced,
    output logic irq
);

    adc_seq_pkg::seq_regs_t q;
    adc_seq_pkg::seq_regs_t d;
    logic rstSyncN;
    logic [1:0] rstStage;
    logic running;
    logic tick;
    logic [7:0] divMask;
    logic [8:0] startupCycles;
    logic [5:0] sampleCycles;
    logic [6:0] lastIdx;
    logic [15:0] sampleVal;
    logic [15:0] finalVal;
    logic winHit;
    logic lastSample;
    logic startReq;
    logic wrCmdStart;
    logic resRead;
    logic [1:0] flagSet;
    logic [1:0] flagClr;

    // ----
    // Derived timing values
    // ----

    // Reset is released through the two stages of rstStage
    assign rstSyncN = rstStage[1];
    // Halted when the processor breaks and debug-run is clear
    assign running = q.enable && !(debugHalt && !q.debugRun);
    // Mask of low prescaler bits; all ones marks one converter clock
    assign divMask = 8'((9'h002 << q.clkDiv) - 9'h001);
    assign tick = running && ((q.prescCnt & divMask) == divMask);
    // Zero code gives no delay; codes 1..5 give 16..256 cycles
    assign startupCycles = (q.startupDly == 3'h0 ||
        q.startupDly > `ADC_STARTUP_MAX_CODE) ? 9'h000 :
        9'(`ADC_STARTUP_BASE << q.startupDly);
    assign sampleCycles = `ADC_SAMPLE_BASE_CYCLES + {1'b0, q.sampleLenExt};
    // Reserved accumulation code falls back to a single sample
    assign lastIdx = (q.accumCount > `ADC_ACCUM_MAX_CODE) ? 7'h00 :
        7'((8'h01 << q.accumCount) - 8'h01);
    assign lastSample = (q.sampleIdx == lastIdx);
    // Eight-bit mode keeps the eight upper bits only
    assign sampleVal = q.resolution_select ? {8'h00, sampleData[9:2]} :
        {6'h00, sampleData};
    assign finalVal = q.accum + sampleVal;

    // ----
    // Window comparison on the accumulated value
    // ----
    always_comb begin
        case (q.windowMode)
            `ADC_WIN_BELOW: winHit = finalVal < q.winLow;
            `ADC_WIN_ABOVE: winHit = finalVal > q.winHigh;
            `ADC_WIN_INSIDE: winHit = (finalVal > q.winLow) &&
                (finalVal < q.winHigh);
            `ADC_WIN_OUTSIDE: winHit = (finalVal < q.winLow) ||
                (finalVal > q.winHigh);
            default: winHit = 1'b0; // Off and reserved codes never match
        endcase
    end

    // ----
    // Bus decode helpers
    // ----
    assign wrCmdStart = regWrite && regAddr == `ADC_CONVERSION_COMMAND_ADDR
        && regWrData[0];
    // Result read in either byte clears both flags
    assign resRead = regRead && (regAddr == `ADC_RESULT_LOW_ADDR ||
        regAddr == `ADC_RESULT_HIGH_ADDR);
    // Event path: rising edge on the synchronised input, when enabled
    assign startReq = running && q.state == adc_seq_pkg::ST_IDLE &&
        (wrCmdStart || (q.eventStartEn && q.evSync && !q.evPrev));

    // ----
    // Next-state logic
    // ----
    always_comb begin
        d = q;
        flagSet = 2'b00;
        flagClr = 2'b00;
        d.rstSync = rstStage; // Copy of the release chain
        d.convertStart = 1'b0;
        // Event synchroniser: first stage is read by the second only
        d.evMeta = startEvent;
        d.evSync = q.evMeta;
        d.evPrev = q.evSync;

        // Register writes
        if (regWrite) begin
            case (regAddr)
                `ADC_MAIN_CONTROL_ADDR: begin
                    d.enable = regWrData[`ADC_ENABLE_BIT];
                    d.free_running = regWrData[`ADC_FREE_RUNNING_BIT];
                    d.resolution_select = regWrData[`ADC_RESOLUTION_SELECT_BIT];
                    // Fresh enable needs the reference to settle first
                    if (regWrData[`ADC_ENABLE_BIT] && !q.enable) begin
                        d.initPending = 1'b1;
                    end
                end
                `ADC_ACCUM_CONTROL_ADDR: d.accumCount = regWrData[2:0];
                `ADC_REF_CLK_CONTROL_ADDR: begin
                    d.sample_capacitor_size = regWrData[`ADC_SAMPLE_CAP_BIT];
                    d.reference_select = regWrData[`ADC_REFERENCE_SELECT_LSB +: 2];
                    d.clkDiv = regWrData[2:0];
                    if (regWrData[`ADC_REFERENCE_SELECT_LSB +: 2] == `ADC_REF_INTERNAL
                            && q.reference_select != `ADC_REF_INTERNAL) begin
                        d.initPending = 1'b1;
                    end
                end
                `ADC_TIMING_CONTROL_ADDR: begin
                    d.startupDly = regWrData[`ADC_STARTUP_DELAY_LSB +: 3];
                    d.autoDelay = regWrData[`ADC_AUTO_DELAY_BIT];
                    d.gapDly = regWrData[3:0];
                end
                `ADC_WINDOW_MODE_CONTROL_ADDR: d.windowMode = regWrData[2:0];
                `ADC_SAMPLE_LENGTH_CONTROL_ADDR: d.sampleLenExt = regWrData[4:0];
                `ADC_INPUT_CHANNEL_SELECT_ADDR: d.inputChannel = regWrData[4:0];
                `ADC_EVENT_TRIGGER_CONTROL_ADDR: d.eventStartEn = regWrData[0];
                `ADC_INTERRUPT_ENABLE_ADDR: d.intEnable = regWrData[1:0];
                `ADC_INTERRUPT_FLAG_STATUS_ADDR: flagClr = regWrData[1:0];
                `ADC_DEBUG_HALT_CONTROL_ADDR: d.debugRun = regWrData[0];
                `ADC_WIN_LOW_LOW_ADDR: d.winLow[7:0] = regWrData;
                `ADC_WIN_LOW_HIGH_ADDR: d.winLow[15:8] = regWrData;
                `ADC_WIN_HIGH_LOW_ADDR: d.winHigh[7:0] = regWrData;
                `ADC_WIN_HIGH_HIGH_ADDR: d.winHigh[15:8] = regWrData;
                default: ; // Writes elsewhere store nothing; a command write still starts via wrCmdStart
            endcase
        end
        if (resRead) begin
            flagClr = 2'b11;
        end
        if (wakeMeasure) begin
            d.initPending = 1'b1;
        end

        // Converter clock divider runs only while active
        d.prescCnt = running ? q.prescCnt + 8'h01 : 8'h00;

        // Sequencer
        if (!q.enable) begin
            // Disabled: nothing counts and any conversion is dropped
            d.state = adc_seq_pkg::ST_IDLE;
            d.startConv = 1'b0;
            d.sampleOpen = 1'b0;
            d.phaseCnt = 9'h000;
        end else if (running) begin
            case (q.state)
                adc_seq_pkg::ST_IDLE: begin
                    if (startReq) begin
                        d.startConv = 1'b1;
                        // Channel is frozen for the whole conversion
                        d.activeChannel = q.inputChannel;
                        d.accum = `ADC_WORD_RESET;
                        d.sampleIdx = 7'h00;
                        d.phaseCnt = 9'h000;
                        if (q.initPending && startupCycles != 9'h000) begin
                            d.state = adc_seq_pkg::ST_STARTUP;
                        end else begin
                            d.initPending = 1'b0;
                            d.state = adc_seq_pkg::ST_SAMPLE;
                            d.sampleOpen = 1'b1;
                        end
                    end
                end
                adc_seq_pkg::ST_STARTUP: begin
                    if (tick) begin
                        d.phaseCnt = q.phaseCnt + 9'h001;
                        if (q.phaseCnt == startupCycles - 9'h001) begin
                            d.initPending = 1'b0;
                            d.phaseCnt = 9'h000;
                            d.state = adc_seq_pkg::ST_SAMPLE;
                            d.sampleOpen = 1'b1;
                        end
                    end
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        d.phaseCnt = q.phaseCnt + 9'h001;
                        if (q.phaseCnt == {3'h0, sampleCycles} - 9'h001) begin
                            d.phaseCnt = 9'h000;
                            d.sampleOpen = 1'b0;
                            d.convertStart = 1'b1;
                            d.state = adc_seq_pkg::ST_CONVERT;
                        end
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (sampleDone) begin
                        // Vary the sampling instant after each sample
                        if (q.autoDelay) begin
                            d.gapDly = q.gapDly + 4'h1;
                        end
                        d.sampleIdx = q.sampleIdx + 7'h01;
                        d.accum = finalVal;
                        if (lastSample) begin
                            d.result = finalVal;
                            d.accum = `ADC_WORD_RESET;
                            d.sampleIdx = 7'h00;
                            flagSet[`ADC_RESULT_READY_BIT] = 1'b1;
                            flagSet[`ADC_WINDOW_MATCH_BIT] = winHit;
                            d.startConv = 1'b0;
                            // Newly written channel takes hold now
                            d.activeChannel = q.inputChannel;
                        end
                        if (!lastSample || q.free_running) begin
                            d.state = adc_seq_pkg::ST_GAP;
                            d.sampleOpen = 1'b1;
                            d.startConv = 1'b1;
                        end else begin
                            d.state = adc_seq_pkg::ST_IDLE;
                        end
                    end
                end
                adc_seq_pkg::ST_GAP: begin
                    // Capacitor stays open for the gap delay
                    if (q.gapDly == 4'h0 || q.phaseCnt[3:0] == q.gapDly) begin
                        d.phaseCnt = 9'h000;
                        d.state = adc_seq_pkg::ST_SAMPLE;
                    end else if (tick) begin
                        d.phaseCnt = q.phaseCnt + 9'h001;
                    end
                end
                default: begin
                    d.state = adc_seq_pkg::ST_IDLE;
                    d.sampleOpen = 1'b0;
                end
            endcase
        end

        // Hardware set beats a same-cycle software clear
        d.interrupt_flag_status = (q.interrupt_flag_status & ~flagClr) | flagSet;

        // Decoded reference and routing, registered for clean outputs
        case (q.reference_select)
            `ADC_REF_INTERNAL: d.refDecode = 3'b001;
            `ADC_REF_SUPPLY: d.refDecode = 3'b010;
            `ADC_REF_EXTERNAL: d.refDecode = 3'b100;
            default: d.refDecode = 3'b000; // Reserved selects nothing
        endcase
        d.pinSelect = 16'h0000;
        d.auxSelect = 3'b000;
        if (q.activeChannel <= `ADC_CHAN_LAST_PIN) begin
            d.pinSelect = 16'h0001 << q.activeChannel[3:0];
        end else begin
            d.auxSelect[0] = q.activeChannel == `ADC_CHAN_COMP_REF;
            d.auxSelect[1] = q.activeChannel == `ADC_CHAN_TEMP;
            d.auxSelect[2] = q.activeChannel == `ADC_CHAN_GROUND;
        end

        // Interrupt request from enabled flags
        d.irq = |(d.interrupt_flag_status & q.intEnable);

        // Read data stands in the cycle after the strobe only
        d.rdData = 8'h00;
        if (regRead) begin
            case (regAddr)
                `ADC_MAIN_CONTROL_ADDR: d.rdData = {5'h00, q.resolution_select,
                    q.free_running, q.enable};
                `ADC_ACCUM_CONTROL_ADDR: d.rdData = {5'h00, q.accumCount};
                `ADC_REF_CLK_CONTROL_ADDR: d.rdData = {1'b0, q.sample_capacitor_size,
                    q.reference_select, 1'b0, q.clkDiv};
                `ADC_TIMING_CONTROL_ADDR: d.rdData = {q.startupDly,
                    q.autoDelay, q.gapDly};
                `ADC_WINDOW_MODE_CONTROL_ADDR: d.rdData = {5'h00, q.windowMode};
                `ADC_SAMPLE_LENGTH_CONTROL_ADDR: d.rdData = {3'h0,
                    q.sampleLenExt};
                `ADC_INPUT_CHANNEL_SELECT_ADDR: d.rdData = {3'h0,
                    q.inputChannel};
                `ADC_CONVERSION_COMMAND_ADDR: d.rdData = {7'h00, q.startConv};
                `ADC_EVENT_TRIGGER_CONTROL_ADDR: d.rdData = {7'h00,
                    q.eventStartEn};
                `ADC_INTERRUPT_ENABLE_ADDR: d.rdData = {6'h00, q.intEnable};
                `ADC_INTERRUPT_FLAG_STATUS_ADDR: d.rdData = {6'h00, q.interrupt_flag_status};
                `ADC_DEBUG_HALT_CONTROL_ADDR: d.rdData = {7'h00, q.debugRun};
                `ADC_RESULT_LOW_ADDR: d.rdData = q.result[7:0];
                `ADC_RESULT_HIGH_ADDR: d.rdData = q.result[15:8];
                `ADC_WIN_LOW_LOW_ADDR: d.rdData = q.winLow[7:0];
                `ADC_WIN_LOW_HIGH_ADDR: d.rdData = q.winLow[15:8];
                `ADC_WIN_HIGH_LOW_ADDR: d.rdData = q.winHigh[7:0];
                `ADC_WIN_HIGH_HIGH_ADDR: d.rdData = q.winHigh[15:8];
                default: d.rdData = 8'h00; // Unmapped reads return zero
            endcase
        end
    end

    // ----
    // State register
    // ----

    // Reset stages take the raw reset; everything else the released copy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstStage <= 2'b00;
        end else begin
            rstStage <= {rstStage[0], 1'b1};
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----
    // Outputs
    // ----
    assign regRdData = q.rdData;
    assign converterTick = tick;
    assign sampleOpen = q.sampleOpen;
    assign convertStart = q.convertStart;
    assign activeChannel = q.activeChannel;
    assign pinSelect = q.pinSelect;
    assign compRefSelect = q.auxSelect[0];
    assign tempSensorSelect = q.auxSelect[1];
    assign groundSelect = q.auxSelect[2];
    assign refInternal = q.refDecode[0];
    assign refSupply = q.refDecode[1];
    assign refExternal = q.refDecode[2];
    assign sampleCapReduced = q.sample_capacitor_size;
    assign irq = q.irq;

endmodule : adc_conversion_sequencer

`default_nettype wire

// ===== adc_seq_assertions.sv
// Port checks of the conversion sequencer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic converterTick,
    input wire logic sampleOpen,
    input wire logic convertStart,
    input wire logic [4:0] activeChannel,
    input wire logic [15:0] pinSelect,
    input wire logic groundSelect,
    input wire logic refInternal,
    input wire logic refSupply,
    input wire logic refExternal
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Steps of a sample: the convert edge, and settled sampling cycles
    sequence s_conv_edge;
        $rose(convertStart);
    endsequence
    sequence s_in_sample;
        sampleOpen && $past(sampleOpen);
    endsequence
    property p_rd_idle;
        !$past(regRead) |-> regRdData == 8'h00;
    endproperty
    property p_tick_gap;
        converterTick |=> !converterTick;
    endproperty
    property p_conv_pulse;
        s_conv_edge |-> $past(sampleOpen) ##1 !convertStart;
    endproperty
    // Routing is only judged once the channel has settled for a sample
    property p_pin_route;
        s_in_sample |-> pinSelect == (activeChannel <= 5'h0F ?
            16'h0001 << activeChannel : 16'h0000);
    endproperty
    property p_gnd_route;
        s_in_sample |-> groundSelect == (activeChannel == 5'h1F);
    endproperty
    property p_chan_hold;
        s_in_sample |-> $stable(activeChannel);
    endproperty
    property p_ref_hot;
        $onehot0({refInternal, refSupply, refExternal});
    endproperty
    property p_pin_hot;
        $onehot0(pinSelect);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    a_tick_gap: assert property (p_tick_gap)
        else $error("converter tick faster than half rate");
    a_conv_pulse: assert property (p_conv_pulse)
        else $error("convert pulse without sampling or too long");
    a_pin_route: assert property (p_pin_route)
        else $error("pin route does not match channel");
    a_gnd_route: assert property (p_gnd_route)
        else $error("ground route does not match channel");
    a_chan_hold: assert property (p_chan_hold)
        else $error("channel moved during a conversion");
    a_ref_hot: assert property (p_ref_hot)
        else $error("more than one reference chosen");
    a_pin_hot: assert property (p_pin_hot)
        else $error("more than one pin routed");
endmodule : adc_seq_checker
bind adc_conversion_sequencer adc_seq_checker chk (.sys_clk, .rst_n,
    .regRead, .regRdData, .converterTick, .sampleOpen, .convertStart,
    .activeChannel, .pinSelect, .groundSelect, .refInternal, .refSupply,
    .refExternal);
`default_nettype wire

// ===== adc_core_model.sv
// Behavioural model of the analog sampling core
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input wire logic sys_clk,
    input wire logic convertStart,
    input wire logic [9:0] nextValue,
    output logic sampleDone = 1'b0,
    output logic [9:0] sampleData = 10'h2AA
);
    int waitCnt = 0;
    logic slow = 1'b0;
    // Prompt and slow answers in turn; data is junk outside the pulse
    always @(posedge sys_clk) begin
        sampleDone <= waitCnt == 1;
        sampleData <= waitCnt == 1 ? nextValue : ~sampleData;
        if (convertStart) begin
            waitCnt <= slow ? 9 : 2;
            slow <= ~slow;
        end else if (waitCnt > 0) waitCnt <= waitCnt - 1;
    end
endmodule : adc_core_model
`default_nettype wire

// ===== adc_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
    logic sys_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic startEvent = 1'b0, debugHalt = 1'b0, wake = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d, v;
    logic [9:0] nextValue = 10'h000, sampleData;
    logic sampleDone, converterTick, sampleOpen, convertStart, irq;
    logic refInternal, refSupply, refExternal, compRef, tempSel, capSmall;
    logic [4:0] activeChannel, chan;
    logic [15:0] pinSelect, expRes;
    logic [7:0] addrTab [10] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h09,
        8'h0A, 8'h0C, 8'h07, 8'h08, 8'h0B};
    logic [7:0] maskTab [10] = '{8'hFF, 8'h07, 8'h1F, 8'h1F, 8'h01,
        8'h03, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [4:0] spec [3] = '{5'h1C, 5'h1E, 5'h1F};
    int err_total = 0, num_checks = 0, ticks, cyc, last, dv, ext;
    always #4 sys_clk = ~sys_clk;
    adc_conversion_sequencer uut (.sys_clk, .rst_n, .regAddr, .regWrData,
        .regWrite, .regRead, .regRdData, .startEvent, .debugHalt,
        .wakeMeasure(wake), .sampleDone, .sampleData, .converterTick,
        .sampleOpen, .convertStart, .activeChannel, .pinSelect,
        .compRefSelect(compRef), .tempSensorSelect(tempSel), .groundSelect(),
        .refInternal, .refSupply, .refExternal, .sampleCapReduced(capSmall),
        .irq);
    adc_core_model core (.sys_clk, .convertStart, .nextValue, .sampleDone,
        .sampleData);
    // ----
    // Bus cycles and comparison
    // ----
    task automatic chk(input string n, input logic [15:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge sys_clk);
        {regAddr, regWrData, regWrite} <= {a, w, 1'b1};
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    // Read data live only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, e, input string n);
        @(posedge sys_clk);
        {regAddr, regRead} <= {a, 1'b1};
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
        if (n != "") chk(n, d, e);
    endtask : rc
    // Event pulse held long enough for the input synchroniser
    task automatic ev;
        @(posedge sys_clk);
        startEvent <= 1'b1;
        repeat (4) @(posedge sys_clk);
        startEvent <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : ev
    task automatic wait_done;
        for (int k = 0; k < 2000 && d[0] !== 1'b0; k++) rc(8'h08, 0, "");
    endtask : wait_done
    function automatic logic hit(input int m, input logic [15:0] r);
        case (m)
            1: return r < 16'h0100;
            2: return r > 16'h0300;
            3: return r > 16'h0100 && r < 16'h0300;
            4: return r < 16'h0100 || r > 16'h0300;
            default: return 1'b0;
        endcase
    endfunction : hit
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // Watchdog sized well past the longest expected run
    initial begin
        #400000;
        err_total++;
        close_out();
    end
    // ----
    // Tests
    // ----
    initial begin
        void'($urandom(35));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int k = 0; k < 10; k++) begin
            rc(addrTab[k], 8'h00, "reset value");
            v = 8'($urandom);
            wr(addrTab[k], v);
            rc(addrTab[k], v & maskTab[k], "readback");
        end
        $display("test registers done");
        for (int r = 0; r < 4; r++) begin
            wr(8'h02, 8'(r << 4 | r << 6));
            repeat (2) @(posedge sys_clk);
            #1 chk("ref", {capSmall, refExternal, refSupply, refInternal},
                16'((r == 3 ? 0 : 1 << r) | r % 2 << 3));
        end
        $display("test reference done");
        foreach (addrTab[k]) if (k < 7) wr(addrTab[k], 8'h00);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h01);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h03);
        for (int i = 0; i < 5; i++) begin
            dv = $urandom % 3;
            ext = $urandom % 8;
            chan = i < 3 ? spec[i] : 5'($urandom % 16);
            nextValue <= i == 2 ? 10'h3FF : 10'($urandom);
            wr(8'h00, 8'(i[0] ? 8'h05 : 8'h01));
            wr(8'h02, 8'(dv));
            wr(8'h05, 8'(ext));
            wr(8'h01, 8'(i % 3));
            wr(8'h04, 8'(i));
            wr(8'h06, 8'(chan));
            wr(8'h0A, i < 4 ? 8'h01 : 8'h02);
            wr(8'h08, 8'h01);
            {ticks, cyc, last} = 0;
            #1;
            while (sampleOpen === 1'b1 && cyc < 9000) begin
                if (converterTick === 1'b1) begin
                    if (ticks > 0) chk("tick gap", 16'(cyc - last),
                        16'(2 << dv));
                    ticks++;
                    last = cyc;
                end
                cyc++;
                @(posedge sys_clk);
                #1;
            end
            chk("sample ticks", 16'(ticks), 16'(2 + ext));
            rc(8'h08, 8'h01, "busy");
            if (i % 3 != 0) wr(8'h06, 8'(chan ^ 5'h01));
            chk("channel", activeChannel, chan);
            chk("route", {tempSel, compRef},
                16'(i < 2 ? 1 << i : 0));
            wait_done();
            expRes = (i[0] ? 16'(nextValue[9:2]) : 16'(nextValue)) << (i % 3);
            v = {6'h00, hit(i, expRes), 1'b1};
            rc(8'h0B, v, "flags");
            chk("irq", irq, i < 4 ? 1'b1 : v[1]);
            if (i == 0) wr(8'h0B, 8'h00);
            rc(8'h0B, v, "flags kept");
            rc(8'h10, expRes[7:0], "result low");
            rc(8'h11, expRes[15:8], "result high");
            rc(8'h0B, 8'h00, "flags cleared");
            chk("irq idle", irq, 1'b0);
        end
        $display("test conversions done");
        wr(8'h09, 8'h01);
        wr(8'h03, 8'h3F);
        wr(8'h05, 8'h1F);
        wr(8'h01, 8'h01);
        debugHalt <= 1'b1;
        ev();
        rc(8'h08, 8'h00, "halted");
        debugHalt <= 1'b0;
        @(posedge sys_clk) wake <= 1'b1;
        @(posedge sys_clk) wake <= 1'b0;
        ev();
        rc(8'h08, 8'h01, "event start");
        chk("startup", sampleOpen, 1'b0);
        wait_done();
        rc(8'h03, 8'h31, "delay wrap");
        $display("test event done");
        close_out();
    end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
